// [pipe_ctl.v]
// pipeline stage control: static front end, dynamic back ends, aborts
//
// Contract
// - integer and memory ops use seven stages, fp operates use ten
// - integer stages: fetch, order, decode, issue, compute1, compute2, write
// - memory ops: address calc, data translate, data hit/miss with write
// - integer pipe is four static stages then three dynamic stages
// - fp pipe reuses four static stages, adds five calc plus writeback
// - static stages may hold; dynamic stages advance every cycle
// - freeze when valid issue candidates cannot all proceed
// - issue resolves all resource conflicts before release
// - after issue only an abort stops an instruction
// - abort flushes all younger instructions, including second of pair; non-exception aborts clear only the static stages
// - exception aborts drain first; non-exception aborts restart at once
// - mispredicts and instruction cache misses are non-exception aborts
// - data cache miss never aborts but may freeze
// - exception detected as late as write stage still kills younger ops
// - latch excepting address; after drain restart at dispatch address
// - drained means no pending register writes and no op can except
// - exactly one bubble after a predicted-taken branch
// - while frozen a front stage advances into a bubble ahead
// - bypass selects allow use of results before register write
// - issue control tracks per-stage state, writes and icache outcome
// - load miss stops memory and address-unit issue, hits complete
`timescale 1ns/100ps
`include "pipe_ctl_regs.vh"
module pipe_ctl
#(
  parameter TAGW = 5   // destination register number width
)
(
  input  wire            mclk,          // core clock, 125 MHz
  input  wire            rst,           // synchronous reset, active high
  input  wire            ce,            // clock enable, freezes all state
  // fetch side
  input  wire            fetch_vld,     // fetch offers an instruction pair
  input  wire [31:0]     fetch_pc,      // address of first of pair
  input  wire            fetch_dual,    // second slot also valid
  input  wire            pred_taken,    // a branch in the pair predicted taken
  input  wire            icache_miss,   // instruction cache miss at write stage
  input  wire [31:0]     icache_pc,     // address to refetch on miss
  // issue side
  input  wire            issue_ok0,     // first slot conflicts resolved
  input  wire            issue_ok1,     // second slot conflicts resolved
  input  wire            slot0_mem,     // first slot uses load port / addr unit
  input  wire            slot1_mem,     // second slot uses load port / addr unit
  input  wire            slot0_fp,      // first slot is fp operate
  input  wire            slot1_fp,      // second slot is fp operate
  input  wire [TAGW-1:0] slot0_dst,     // first slot destination register
  input  wire [TAGW-1:0] slot1_dst,     // second slot destination register
  input  wire [TAGW-1:0] src_reg,       // operand register to check for bypass
  // execution feedback
  input  wire            mispredict,    // branch or call/return mispredict
  input  wire [31:0]     mispredict_pc, // corrected target
  input  wire            exc_req,       // exception or interrupt
  input  wire [2:0]      exc_stage,     // back-end stage index 0..2 of culprit
  input  wire [31:0]     exc_pc,        // address of excepting instruction
  input  wire            dmiss,         // data cache load miss at hit/miss
  input  wire            dmiss_done,    // requested fill data returned
  // outputs
  output reg             issue0,        // first slot issues this cycle
  output reg             issue1,        // second slot issues this cycle
  output reg             freeze,        // valid candidates held at issue
  output reg  [3:0]      front_adv,     // per static stage advance
  output reg  [3:0]      front_vld,     // per static stage valid
  output reg  [2:0]      int_vld,       // integer dynamic stage valid
  output reg  [5:0]      fp_vld,        // fp dynamic stage valid
  output reg             abort,         // redirect pulse to fetch
  output reg             abort_type,    // 1 exception, 0 non-exception
  output reg  [31:0]     abort_pc,      // redirect address
  output reg  [31:0]     exception_address_reg, // latched excepting pc
  output reg             draining,      // exception drain in progress
  output reg             mem_hold,      // memory issue stopped by load miss
  output reg  [1:0]      bypass_sel     // 0 regfile,1 stage4,2 stage5,3 stage6
);

  // ***************************************************************
  // state
  // ***************************************************************
  reg [3:0]  fv_reg;           // static stage valid
  reg [3:0]  fv_next;
  reg [1:0]  st_reg;
  reg [1:0]  st_next;
  reg        bubble_reg;       // one bubble owed after taken prediction
  reg        bubble_next;
  reg        mem_hold_reg;
  reg        iss0;
  reg        iss1;
  reg        frz;
  reg [3:0]  adv;
  reg [2:0]  ikill;
  reg [5:0]  fkill;
  reg        nonexc;
  reg        excf;
  reg [31:0] redir;

  wire [2:0]        iv;
  wire [3*TAGW-1:0] itag;
  wire [5:0]        fv;

  // outstanding register writes of any stage beyond issue
  wire pend_int = |iv;
  wire pend_fp  = |fv;
  wire drained  = ~pend_int & ~pend_fp;

  // ***************************************************************
  // helper functions
  // ***************************************************************
  // mask of dynamic stages younger than the given stage index
  function [2:0] younger_mask;
    input [2:0] s;
    begin
      case (s)
        3'h0:    younger_mask = 3'h0;
        3'h1:    younger_mask = 3'h1;
        3'h2:    younger_mask = 3'h3;
        default: younger_mask = 3'h7;
      endcase
    end
  endfunction

  // does a stage tag match the operand register
  function hit;
    input            v;
    input [TAGW-1:0] t;
    input [TAGW-1:0] r;
    begin
      hit = v & (t == r);
    end
  endfunction

  // ***************************************************************
  // issue, freeze and abort decode
  // ***************************************************************
  always @*
  begin
    nonexc = mispredict | icache_miss;
    excf   = exc_req & (st_reg == `ST_RUN);
    redir  = icache_miss ? icache_pc : mispredict_pc;
    // memory class stopped during load miss; data miss never aborts
    iss0 = fv_reg[`STG_ISSUE] & issue_ok0 & (st_reg == `ST_RUN)
           & ~(slot0_mem & mem_hold_reg) & ~excf & ~nonexc;
    iss1 = iss0 & fetch_dual & issue_ok1
           & ~(slot1_mem & mem_hold_reg);
    // a flush cycle is not a freeze: the held op is being thrown away
    frz  = fv_reg[`STG_ISSUE] & (st_reg == `ST_RUN) & ~excf & ~nonexc
           & ~(iss0 & (iss1 | ~fetch_dual));
    // younger ops in dynamic stages die; culprit stage also cleared
    ikill = excf ? younger_mask(exc_stage + 3'h1) : 3'h0;
    fkill = excf ? 6'h3f : 6'h00;
    // static stage advance: free when not frozen, else into a bubble
    // a stage loads only if it is empty or its own op moves on, so a
    // held op is never overwritten by the one behind it
    adv[3] = ~frz | ~fv_reg[3];
    adv[2] = adv[3] | ~fv_reg[2];
    adv[1] = adv[2] | ~fv_reg[1];
    adv[0] = adv[1] | ~fv_reg[0];
    // front valid next state
    fv_next = fv_reg;
    if (excf | nonexc | (st_reg != `ST_RUN))
      fv_next = 4'h0;
    else
    begin
      if (adv[3])
        fv_next[3] = fv_reg[2];
      if (adv[2])
        fv_next[2] = fv_reg[1];
      if (adv[1])
        fv_next[1] = fv_reg[0];
      if (adv[0])
        fv_next[0] = fetch_vld & ~bubble_reg;
      if (frz & iss0 & ~iss1)
        fv_next[3] = 1'b1;        // second of pair held at issue
    end
  end

  // a taken prediction owes one empty fetch slot right behind it; an
  // abort clears the debt because the refetch starts a fresh stream
  always @*
  begin
    bubble_next = bubble_reg;
    if (excf | nonexc | (st_reg != `ST_RUN))
      bubble_next = 1'b0;
    else if (adv[0])
      bubble_next = pred_taken & fetch_vld & ~bubble_reg;
  end

  // ***************************************************************
  // abort sequencing
  // ***************************************************************
  always @*
  begin
    st_next = st_reg;
    case (st_reg)
      `ST_RUN:
        if (excf)
          st_next = `ST_DRAIN;
      `ST_DRAIN:
        if (drained)
          st_next = `ST_RESTART;
      `ST_RESTART:
        st_next = `ST_RUN;
      default:
        st_next = `ST_RUN;
    endcase
  end

  // ***************************************************************
  // dynamic back ends
  // ***************************************************************
  // integer / memory back end: compute1, compute2, write
  dyn_shift #(.DEPTH(`INT_DYN_STAGES), .WIDTH(TAGW)) u_int
  (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .in_vld ((iss0 & ~slot0_fp) | (iss1 & ~slot1_fp)),
    .in_tag ((iss0 & ~slot0_fp) ? slot0_dst : slot1_dst),
    .kill   (ikill),
    .vld    (iv),
    .tag    (itag)
  );

  // fp back end: five calc stages then fp writeback
  dyn_shift #(.DEPTH(`FP_DYN_STAGES), .WIDTH(TAGW)) u_fp
  (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .in_vld ((iss0 & slot0_fp) | (iss1 & slot1_fp)),
    .in_tag ((iss0 & slot0_fp) ? slot0_dst : slot1_dst),
    .kill   (fkill),
    .vld    (fv),
    .tag    ()
  );

  // ***************************************************************
  // registered control and outputs
  // ***************************************************************
  // one flop group keeps every output straight from a flip-flop
  always @(posedge mclk)
  begin
    if (rst)
    begin
      fv_reg                <= 4'h0;
      st_reg                <= `ST_RUN;
      bubble_reg            <= 1'b0;
      mem_hold_reg          <= 1'b0;
      issue0                <= 1'b0;
      issue1                <= 1'b0;
      freeze                <= 1'b0;
      front_adv             <= 4'h0;
      front_vld             <= 4'h0;
      int_vld               <= 3'h0;
      fp_vld                <= 6'h00;
      abort                 <= 1'b0;
      abort_type            <= `ABORT_NONEXC;
      abort_pc              <= `RESET_PC;
      exception_address_reg <= `RESET_PC;
      draining              <= 1'b0;
      mem_hold              <= 1'b0;
      bypass_sel            <= 2'h0;
    end
    else if (ce)
    begin
      fv_reg <= fv_next;
      st_reg <= st_next;
      bubble_reg <= bubble_next;
      // set wins over release so a new miss is never lost
      if (dmiss)
        mem_hold_reg <= 1'b1;
      else if (dmiss_done)
        mem_hold_reg <= 1'b0;
      if (excf)
      begin
        exception_address_reg <= exc_pc;
      end
      issue0    <= iss0;
      issue1    <= iss1;
      freeze    <= frz;
      front_adv <= adv;
      front_vld <= fv_next;
      int_vld   <= iv;
      fp_vld    <= fv;
      draining  <= (st_next == `ST_DRAIN);
      // output takes the flag's next value so it drops with the release
      mem_hold  <= dmiss | (mem_hold_reg & ~dmiss_done);
      // abort pulse: immediate for non-exception, after drain for exception
      abort      <= (nonexc & (st_reg == `ST_RUN)) | (st_reg == `ST_RESTART);
      abort_type <= (st_reg == `ST_RESTART) ? `ABORT_EXC : `ABORT_NONEXC;
      abort_pc   <= (st_reg == `ST_RESTART) ? `DISPATCH_ADDR : redir;
      // nearest producer wins so the newest value is forwarded
      if (hit(iv[0], itag[0 +: TAGW], src_reg))
        bypass_sel <= 2'h1;
      else if (hit(iv[1], itag[TAGW +: TAGW], src_reg))
        bypass_sel <= 2'h2;
      else if (hit(iv[2], itag[2*TAGW +: TAGW], src_reg))
        bypass_sel <= 2'h3;
      else
        bypass_sel <= 2'h0;
    end
  end

endmodule

// [pipe_ctl_regs.vh]
// constants for the pipeline stage control block
`ifndef PIPE_CTL_REGS_VH
`define PIPE_CTL_REGS_VH
// stage counts
`define INT_STAGES      7
`define FP_STAGES       10
`define STATIC_STAGES   4
`define INT_DYN_STAGES  3
`define FP_DYN_STAGES   6
// stage indices of the integer pipe
`define STG_FETCH       0
`define STG_ORDER       1
`define STG_DECODE      2
`define STG_ISSUE       3
`define STG_COMPUTE1    4
`define STG_COMPUTE2    5
`define STG_WRITE       6
// abort type encoding
`define ABORT_NONEXC    1'b0
`define ABORT_EXC       1'b1
// reset and restart addresses
`define RESET_PC        32'h0000_0000
`define DISPATCH_ADDR   32'h0000_0100
// control states
`define ST_RUN          2'h0
`define ST_DRAIN        2'h1
`define ST_RESTART      2'h2
`endif

// [dyn_shift.v]
// dynamic stage chain that advances every cycle
`timescale 1ns/100ps
module dyn_shift
#(
  parameter DEPTH = 3,
  parameter WIDTH = 8
)
(
  input  wire             mclk,     // core clock
  input  wire             rst,      // synchronous reset
  input  wire             ce,       // clock enable
  input  wire             in_vld,   // entry valid from issue
  input  wire [WIDTH-1:0] in_tag,   // entry tag (dest register etc)
  input  wire [DEPTH-1:0] kill,     // per-stage abort squash
  output wire [DEPTH-1:0] vld,      // per-stage valid
  output wire [DEPTH*WIDTH-1:0] tag // per-stage tag, stage 0 low
);

  reg [DEPTH-1:0]       vld_reg;
  reg [DEPTH*WIDTH-1:0] tag_reg;
  genvar g;

  assign vld = vld_reg;
  assign tag = tag_reg;

  // each stage takes the one behind it; no hold term exists here
  // the head is split off so no stage ever selects a stage below zero
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : stg
      if (g == 0)
      begin : head
        always @(posedge mclk)
        begin
          if (rst)
          begin
            vld_reg[g]                <= 1'b0;
            tag_reg[g*WIDTH +: WIDTH] <= {WIDTH{1'b0}};
          end
          else if (ce)
          begin
            vld_reg[g]                <= in_vld & ~kill[g];
            tag_reg[g*WIDTH +: WIDTH] <= in_tag;
          end
        end
      end
      else
      begin : body
        always @(posedge mclk)
        begin
          if (rst)
          begin
            vld_reg[g]                <= 1'b0;
            tag_reg[g*WIDTH +: WIDTH] <= {WIDTH{1'b0}};
          end
          else if (ce)
          begin
            vld_reg[g]                <= vld_reg[g-1] & ~kill[g];
            tag_reg[g*WIDTH +: WIDTH] <= tag_reg[(g-1)*WIDTH +: WIDTH];
          end
        end
      end
    end
  endgenerate

endmodule

// [pipe_ctl_props.sv]
// concurrent checks on the pipeline stage control ports
`timescale 1ns/100ps
`include "pipe_ctl_regs.vh"
module pipe_ctl_props
(
  input logic        mclk,                  // core clock
  input logic        rst,                   // sync reset
  input logic        ce,                    // clock enable
  input logic        mispredict,            // mispredict pulse
  input logic [31:0] mispredict_pc,         // corrected target
  input logic        icache_miss,           // icache miss pulse
  input logic [31:0] icache_pc,             // refetch address
  input logic        exc_req,               // exception request
  input logic [31:0] exc_pc,                // excepting address
  input logic        dmiss,                 // load miss
  input logic        dmiss_done,            // fill returned
  input logic        issue0,                // first slot issue
  input logic        issue1,                // second slot issue
  input logic        freeze,                // freeze view
  input logic [2:0]  int_vld,               // int dynamic valid
  input logic [5:0]  fp_vld,                // fp dynamic valid
  input logic        abort,                 // redirect pulse
  input logic        abort_type,            // exception flag
  input logic [31:0] abort_pc,              // redirect address
  input logic [31:0] exception_address_reg, // latched pc
  input logic        draining,              // drain level
  input logic        mem_hold               // memory issue hold
);
  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_quick_redirect(logic [31:0] pc);
    abort && !abort_type && abort_pc == pc;
  endsequence
  sequence s_exc_restart;
    abort && abort_type && abort_pc == `DISPATCH_ADDR;
  endsequence
  // restart may lag the end of drain by the restart state
  chk_mispred_redirect: assert property (ce && mispredict && !icache_miss && !exc_req && !draining |=> s_quick_redirect($past(mispredict_pc))) else $error("mispredict redirect wrong");
  chk_icmiss_redirect: assert property (ce && icache_miss && !mispredict && !exc_req && !draining |=> s_quick_redirect($past(icache_pc))) else $error("icache miss redirect wrong");
  chk_exc_latch: assert property (ce && exc_req && !draining && !$past(draining) && !abort |=> draining && exception_address_reg == $past(exc_pc)) else $error("exception not latched");
  chk_drain_restart: assert property ($fell(draining) |-> ##[0:2] s_exc_restart) else $error("no restart after drain");
  chk_drain_empty: assert property (abort && abort_type |-> abort_pc == `DISPATCH_ADDR && int_vld == 3'h0 && fp_vld == 6'h0) else $error("restart before drain");
  chk_pair_order: assert property (issue1 |-> issue0) else $error("second slot issued alone");
  chk_freeze_pair: assert property (freeze |-> !issue1) else $error("freeze with full pair issued");
  chk_dyn_advance: assert property (ce |=> (int_vld[2:1] & ~$past(int_vld[1:0])) == 2'h0 && (fp_vld[5:1] & ~$past(fp_vld[4:0])) == 5'h0) else $error("dynamic stage held");
  chk_hold_set: assert property (ce && dmiss |=> mem_hold && !abort) else $error("load miss not holding");
  chk_hold_clear: assert property (ce && dmiss_done && !dmiss |=> !mem_hold) else $error("hold not cleared");
endmodule
bind pipe_ctl pipe_ctl_props i_props (.mclk, .rst, .ce, .mispredict,
  .mispredict_pc, .icache_miss, .icache_pc, .exc_req, .exc_pc, .dmiss,
  .dmiss_done, .issue0, .issue1, .freeze, .int_vld, .fp_vld, .abort,
  .abort_type, .abort_pc, .exception_address_reg, .draining, .mem_hold);

// [pipe_ctl_exec_model.sv]
// far-side model: execution units granting issue and returning load fills
`timescale 1ns/100ps
module pipe_ctl_exec_model
(
  input  logic       mclk,      // core clock
  input  logic       rst,       // sync reset
  input  logic [1:0] slow,      // 0 grant all, 1 hold slot1, 2 hold all
  input  logic       mem_hold,  // load miss pending
  output logic       issue_ok0, // first slot clear
  output logic       issue_ok1, // second slot clear
  output logic       dmiss_done // fill data back
);
  logic [3:0] fill_cnt = 4'h0;
  // grants follow the requested stall mode
  assign issue_ok0 = (slow != 2'h2);
  assign issue_ok1 = (slow == 2'h0);
  assign dmiss_done = (fill_cnt == 4'hb);
  // slow fill so that held issue stays visible for a while
  always @(negedge mclk)
  begin
    if (rst || !mem_hold)
      fill_cnt <= 4'h0;
    else if (fill_cnt != 4'hb)
      fill_cnt <= fill_cnt + 4'h1;
  end
endmodule

// [cpu_pipeline_stage_control_tb.sv]
// self-checking bench for the pipeline stage control block
`timescale 1ns/100ps
`include "pipe_ctl_regs.vh"
`define chk(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module cpu_pipeline_stage_control_tb;
  logic        mclk, rst, ce, fetch_vld, fetch_dual, pred_taken, icache_miss;
  logic        issue_ok0, issue_ok1, slot0_mem, slot1_mem, slot0_fp, slot1_fp;
  logic        mispredict, exc_req, dmiss, dmiss_done, issue0, issue1, freeze;
  logic        abort, abort_type, draining, mem_hold, seen;
  logic [31:0] fetch_pc, icache_pc, mispredict_pc, exc_pc, abort_pc;
  logic [31:0] exception_address_reg;
  logic [4:0]  slot0_dst, slot1_dst, src_reg;
  logic [3:0]  front_adv, front_vld;
  logic [2:0]  exc_stage, int_vld;
  logic [5:0]  fp_vld;
  logic [1:0]  bypass_sel, slow;
  int          errors, cmp_count, cycles, n;
  pipe_ctl #(.TAGW(5)) i_dut (.mclk, .rst, .ce, .fetch_vld, .fetch_pc,
    .fetch_dual, .pred_taken, .icache_miss, .icache_pc, .issue_ok0,
    .issue_ok1, .slot0_mem, .slot1_mem, .slot0_fp, .slot1_fp, .slot0_dst,
    .slot1_dst, .src_reg, .mispredict, .mispredict_pc, .exc_req, .exc_stage,
    .exc_pc, .dmiss, .dmiss_done, .issue0, .issue1, .freeze, .front_adv,
    .front_vld, .int_vld, .fp_vld, .abort, .abort_type, .abort_pc,
    .exception_address_reg, .draining, .mem_hold, .bypass_sel);
  pipe_ctl_exec_model i_exec (.mclk, .rst, .slow, .mem_hold, .issue_ok0,
    .issue_ok1, .dmiss_done);
  // ****************************************
  // clock, watchdog and verdict
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // a hang ends the run as a failure rather than stalling it
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test;
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    `chk({abort, draining, mem_hold, issue0, front_vld, int_vld}, 11'h0)
  endtask
  // one op walks four static then three or six dynamic stages
  task t_flow(input logic fp);
    slot0_fp = fp;
    src_reg = slot0_dst;
    fetch_vld = 1'b1;
    tick(1);
    fetch_vld = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      `chk(front_vld, 4'h1 << i)
      tick(1);
    end
    for (n = 0; int_vld === 3'h0 && fp_vld === 6'h0 && n < 10; n++)
      tick(1);
    for (int i = 0; i < (fp ? 6 : 3); i++)
    begin
      `chk({fp_vld, int_vld}, (fp ? 9'h8 : 9'h1) << i)
      if (!fp)
        `chk(bypass_sel, 2'(i + 1))
      tick(1);
    end
    `chk({fp_vld, int_vld}, 9'h0)
    `chk(bypass_sel, 2'h0)
    slot0_fp = 1'b0;
    src_reg = 5'h9;
  endtask
  task t_freeze;
    slow = 2'h2;
    fetch_dual = 1'b1;
    slot1_fp = 1'b1;
    fetch_vld = 1'b1;
    tick(1);
    fetch_vld = 1'b0;
    tick(8);
    `chk({front_vld[3], freeze, issue0}, 3'h6)
    `chk(front_adv, 4'h7)
    slow = 2'h1;
    tick(3);
    `chk({front_vld[3], issue1, freeze}, 3'h5)
    slow = 2'h0;
    tick(3);
    `chk({front_vld[3], freeze}, 2'h0)
    fetch_dual = 1'b0;
    slot1_fp = 1'b0;
    tick(12);
  endtask
  // both quick-restart causes redirect at once and flush the front
  task t_redirect;
    for (int k = 0; k < 2; k++)
    begin
      fetch_vld = 1'b1;
      tick(2);
      fetch_vld = 1'b0;
      mispredict = (k == 0);
      icache_miss = (k == 1);
      tick(1);
      mispredict = 1'b0;
      icache_miss = 1'b0;
      `chk({abort, abort_type}, 2'h2)
      `chk(abort_pc, k ? icache_pc : mispredict_pc)
      tick(1);
      `chk({abort, front_vld}, 5'h0)
      tick(8);
    end
  endtask
  task t_exception;
    fetch_vld = 1'b1;
    tick(1);
    fetch_vld = 1'b0;
    tick(6);
    exc_req = 1'b1;
    tick(1);
    exc_req = 1'b0;
    `chk({draining, exception_address_reg}, {1'b1, exc_pc})
    for (n = 0; abort !== 1'b1 && n < 20; n++)
      tick(1);
    `chk({abort, abort_type, abort_pc}, {2'h3, `DISPATCH_ADDR})
    `chk({int_vld, fp_vld, front_vld}, 13'h0)
    tick(4);
  endtask
  // a memory op waits out the load miss, then issues
  task t_dmiss;
    dmiss = 1'b1;
    slot0_mem = 1'b1;
    tick(1);
    dmiss = 1'b0;
    `chk({mem_hold, abort}, 2'h2)
    fetch_vld = 1'b1;
    tick(1);
    fetch_vld = 1'b0;
    seen = 1'b0;
    for (n = 0; mem_hold === 1'b1 && n < 20; n++)
    begin
      seen = seen | issue0;
      tick(1);
    end
    `chk({seen, mem_hold}, 2'h0)
    for (n = 0; issue0 !== 1'b1 && n < 8; n++)
      tick(1);
    `chk(issue0, 1'b1)
    slot0_mem = 1'b0;
    tick(8);
  endtask
  // a taken prediction leaves exactly one empty slot behind the branch
  task t_bubble;
    {fetch_vld, pred_taken} = 2'h3;
    tick(1);
    pred_taken = 1'b0;
    tick(1);
    `chk(front_vld, 4'h2)
    tick(1);
    fetch_vld = 1'b0;
    `chk(front_vld, 4'h5)
    tick(10);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rst, ce} = 2'h3;
    {fetch_vld, fetch_dual, pred_taken, icache_miss, mispredict} = 5'h0;
    {slot0_mem, slot1_mem, slot0_fp, slot1_fp, exc_req, dmiss} = 6'h0;
    {slot0_dst, slot1_dst, src_reg, slow} = {5'h3, 5'h4, 5'h9, 2'h0};
    {fetch_pc, icache_pc, mispredict_pc} = {32'h40, 32'h3040, 32'h2000};
    {exc_pc, exc_stage} = {32'h4a10, 3'h2};
    tick(5);
    rst = 1'b0;
    t_reset();
    t_flow(1'b0);
    t_flow(1'b1);
    t_freeze();
    t_redirect();
    t_exception();
    t_dmiss();
    t_bubble();
    end_of_test();
  end
endmodule
